// [hdl/sec_lock_pkg.sv]
// Constants, types and register map of the drive security lock state machine
// Functional notes
// [RULE1] Six security opcodes F1..F6: set, unlock, erase prepare, erase unit, freeze, disable.
// [RULE2] With a user password set, reset yields locked mode; media commands are refused.
// [RULE3] Good unlock or erase unit in locked mode moves to unlocked, media re-enabled.
// [RULE4] No user password at reset means unlocked mode with every command enabled.
// [RULE5] Frozen mode accepts all but lock-changing and password-changing commands.
// [RULE6] Freeze command enters frozen mode; no command can leave it.
// [RULE7] High level with lock enabled: correct master password unlocks too.
// [RULE8] Maximum level: only erase unit with master password recovers; it erases data.
// [RULE9] Setting master password never enables lock, yet master can unlock.
// [RULE10] Identify word 92 shows revision code of last master change, 0001h..FFFEh.
// [RULE11] Revision code defaults to FFFEh until a master password is set.
// [RULE12] Setting user password enables lock; locked from next power-on or hard reset. Here power-on clears the password and gives unlocked.
// [RULE13] One mismatch counter counts every failed comparison, master or user.
// [RULE14] At count 5 set exhausted flag (word 128 bit 4); abort unlock and erase unit.
// [RULE15] Power-on or hard reset clears counter and exhausted flag.
// [RULE16] Locked aborts media, set, disable, freeze; frozen aborts set, unlock, disable, erases.
// [RULE17] Mismatch counter saturates at its limit, never wraps.
package sec_lock_pkg;

  // Security opcodes
  localparam logic [7:0] OP_SET_PW = 8'hF1;
  localparam logic [7:0] OP_UNLOCK = 8'hF2;
  localparam logic [7:0] OP_ERASE_PREP = 8'hF3;
  localparam logic [7:0] OP_ERASE_UNIT = 8'hF4;
  localparam logic [7:0] OP_FREEZE = 8'hF5;
  localparam logic [7:0] OP_DISABLE_PW = 8'hF6;

  // Register byte offsets
  localparam logic [7:0] CMD_OFS = 8'h00;
  localparam logic [7:0] PASSWORD_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] IDENT_OFS = 8'h0C;
  localparam logic [7:0] IRQ_STATUS_OFS = 8'h10;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h14;

  // Reset values and limits
  localparam logic [15:0] REV_DEFAULT = 16'hFFFE;
  localparam logic [15:0] REV_MIN = 16'h0001;
  localparam logic [15:0] REV_MAX = 16'hFFFE;
  localparam logic [31:0] MASTER_PW_DEFAULT = 32'h0000_0000;
  localparam logic [2:0] MISMATCH_LIMIT = 3'h5;
  localparam int EXHAUST_BIT = 4;

  // Interrupt bit positions
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ABORT = 1;
  localparam int IRQ_EXHAUST = 2;
  localparam int IRQ_W = 3;

  // Security modes, one-hot
  typedef enum logic [2:0] {
    MODE_LOCKED = 3'b001,
    MODE_UNLOCKED = 3'b010,
    MODE_FROZEN = 3'b100
  } lock_mode_t;

  // Command word written to the command register
  typedef struct packed {
    logic [15:0] rev_code;  // Master revision code for set password
    logic [4:0] rsvd;
    logic level_max;        // Security level for a user set password
    logic sel_master;       // Password identifier: 1 master, 0 user
    logic media;            // Ordinary command that touches the media
    logic [7:0] opcode;
  } cmd_word_t;

  // Outcome of the last command
  typedef struct packed {
    logic aborted;
    logic done;
  } cmd_result_t;

endpackage

// [hdl/drive_security_lock_fsm.sv]
// Security lock state machine with an Avalon-MM register slave
//
// Decided for this implementation: the register offsets and register access over Avalon-MM.
`timescale 1ns/10ps
module drive_security_lock_fsm (
  input wire logic ref_clk_in,                  // 125 MHz clock
  input wire logic rst_b_in,                    // Power-on reset, sync, active low
  input wire logic hard_reset_b_in,             // Hard reset pin, async, active low
  input wire logic [7:0] avs_address_in,        // Byte address
  input wire logic avs_read_in,                 // Read request
  input wire logic avs_write_in,                // Write request
  input wire logic [3:0] avs_byteenable_in,     // Write byte lanes
  input wire logic [31:0] avs_writedata_in,     // Write data
  output logic [31:0] avs_readdata_out,         // Read data
  output logic avs_waitrequest_out,             // Stall until answer
  output logic irq_out,                         // Level interrupt
  output logic media_enable_out,                // Media commands allowed
  output logic erase_out,                       // One-cycle user data erase pulse
  output sec_lock_pkg::lock_mode_t mode_out     // Current security mode
);
  import sec_lock_pkg::*;

  lock_mode_t mode;
  cmd_word_t cmd;
  cmd_result_t result;
  logic [31:0] pw_buf;
  logic [31:0] user_pw;
  logic [31:0] master_pw;
  logic lock_en;
  logic level_max;
  logic [15:0] master_rev;
  logic [2:0] miss_cnt;
  logic exhausted;
  logic prepared;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;
  logic hard_meta;
  logic hard_sync;
  logic hard_rst;
  logic access;
  logic wr_go;
  logic exec;
  logic blocked;
  logic checked;
  logic pw_ok;
  logic miss;
  logic abort;
  logic [31:0] next_rdata;
  logic [15:0] word128;
  logic [IRQ_W-1:0] events;

  // Byte-lane merge for partial writes
  function automatic logic [31:0] merge_be(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        res[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return res;
  endfunction

  // Hard reset pin synchroniser; only the second stage is used downstream
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_b_in)
    begin
      hard_meta <= 1'b1;
      hard_sync <= 1'b1;
    end
    else
    begin
      hard_meta <= hard_reset_b_in;
      hard_sync <= hard_meta;
    end
  end
  assign hard_rst = !hard_sync;

  // Bus handshake: one wait cycle per access, completion when waitrequest is low
  assign access = avs_read_in || avs_write_in;
  assign wr_go = avs_write_in && !avs_waitrequest_out;
  assign exec = wr_go && (avs_address_in == CMD_OFS) && avs_byteenable_in[0];

  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_b_in)
    begin
      avs_waitrequest_out <= 1'b1;
    end
    else
    begin
      avs_waitrequest_out <= !(access && avs_waitrequest_out);
    end
  end

  // Command word decoded straight off the bus; only meaningful while exec is high
  assign cmd = cmd_word_t'(avs_writedata_in);

  // Command gating and password check
  always_comb
  begin
    blocked = 1'b0;
    pw_ok = 1'b0;
    case (mode)
      MODE_LOCKED:
      begin
        blocked = cmd.media || (cmd.opcode == OP_SET_PW) ||        // [RULE2] [RULE16]
                  (cmd.opcode == OP_DISABLE_PW) || (cmd.opcode == OP_FREEZE);
      end
      MODE_FROZEN:
      begin
        blocked = (cmd.opcode == OP_SET_PW) || (cmd.opcode == OP_UNLOCK) ||  // [RULE5] [RULE16]
                  (cmd.opcode == OP_ERASE_PREP) || (cmd.opcode == OP_ERASE_UNIT) ||
                  (cmd.opcode == OP_DISABLE_PW);
      end
      default:
      begin
        blocked = 1'b0;
      end
    endcase
    // Exhausted attempts shut out both password-unlocking paths
    if (exhausted && ((cmd.opcode == OP_UNLOCK) || (cmd.opcode == OP_ERASE_UNIT)))  // [RULE14]
    begin
      blocked = 1'b1;
    end
    // Erase unit must directly follow erase prepare
    if ((cmd.opcode == OP_ERASE_UNIT) && !prepared)
    begin
      blocked = 1'b1;
    end
    if (cmd.sel_master)
    begin
      // Master unlock is honoured only at high level; erase unit takes it at any level
      pw_ok = (pw_buf == master_pw) &&
              ((cmd.opcode != OP_UNLOCK) || !level_max);  // [RULE7] [RULE8] [RULE9]
    end
    else
    begin
      pw_ok = (pw_buf == user_pw);
    end
  end

  assign checked = exec && !blocked && ((cmd.opcode == OP_UNLOCK) ||
                   (cmd.opcode == OP_ERASE_UNIT) || (cmd.opcode == OP_DISABLE_PW));
  assign miss = checked && !pw_ok;  // [RULE13]
  assign abort = blocked || (checked && !pw_ok);

  // Security mode
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_b_in)
    begin
      mode <= MODE_UNLOCKED;  // [RULE4]
    end
    else if (hard_rst)
    begin
      // Lock takes effect only from a reset, never at the set command itself
      mode <= lock_en ? MODE_LOCKED : MODE_UNLOCKED;  // [RULE2] [RULE4] [RULE12]
    end
    else if (exec && !abort)
    begin
      case (cmd.opcode)
        OP_UNLOCK, OP_ERASE_UNIT:
        begin
          if (mode == MODE_LOCKED)
          begin
            mode <= MODE_UNLOCKED;  // [RULE3] [RULE8]
          end
        end
        OP_FREEZE:
        begin
          mode <= MODE_FROZEN;  // [RULE6]
        end
        default:
        begin
          mode <= mode;
        end
      endcase
    end
  end

  // Password store; survives hard reset, reset at power-on; erase unit and disable clear the user password
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_b_in)
    begin
      user_pw <= 32'h0000_0000;
      master_pw <= MASTER_PW_DEFAULT;
      lock_en <= 1'b0;
      level_max <= 1'b0;
      master_rev <= REV_DEFAULT;  // [RULE11]
    end
    else if (exec && !abort)
    begin
      case (cmd.opcode)
        OP_SET_PW:
        begin
          if (cmd.sel_master)
          begin
            // Master change leaves the lock function untouched
            master_pw <= pw_buf;  // [RULE9]
            if ((cmd.rev_code >= REV_MIN) && (cmd.rev_code <= REV_MAX))
            begin
              master_rev <= cmd.rev_code;  // [RULE10]
            end
          end
          else
          begin
            user_pw <= pw_buf;
            lock_en <= 1'b1;  // [RULE12]
            level_max <= cmd.level_max;
          end
        end
        OP_ERASE_UNIT, OP_DISABLE_PW:
        begin
          user_pw <= 32'h0000_0000;
          lock_en <= 1'b0;
        end
        default:
        begin
          lock_en <= lock_en;
        end
      endcase
    end
  end

  // Mismatch counter and exhausted flag
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_b_in || hard_rst)
    begin
      miss_cnt <= 3'h0;  // [RULE15]
      exhausted <= 1'b0;
    end
    else if (miss && (miss_cnt != MISMATCH_LIMIT))
    begin
      // Saturating so the exhausted state cannot age out by wrapping
      miss_cnt <= miss_cnt + 3'h1;  // [RULE13] [RULE17]
      exhausted <= (miss_cnt == MISMATCH_LIMIT - 3'h1);  // [RULE14]
    end
  end

  // Erase prepare arms only the very next command
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_b_in || hard_rst)
    begin
      prepared <= 1'b0;
    end
    else if (exec)
    begin
      prepared <= !abort && (cmd.opcode == OP_ERASE_PREP);
    end
  end

  // Result of last command and erase strobe
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_b_in)
    begin
      result <= '0;
      erase_out <= 1'b0;
    end
    else
    begin
      erase_out <= exec && !abort && (cmd.opcode == OP_ERASE_UNIT);  // [RULE8]
      if (exec)
      begin
        result.done <= !abort;  // [RULE1]
        result.aborted <= abort;
      end
    end
  end

  // Password buffer, write-only from the bus
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_b_in)
    begin
      pw_buf <= 32'h0000_0000;
    end
    else if (wr_go && (avs_address_in == PASSWORD_OFS))
    begin
      pw_buf <= merge_be(pw_buf, avs_writedata_in, avs_byteenable_in);
    end
  end

  // Interrupt status and mask; a new event beats a same-cycle clear
  assign events = {exec && miss && (miss_cnt == MISMATCH_LIMIT - 3'h1), exec && abort,
                   exec && !abort};
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_b_in)
    begin
      irq_status <= '0;
      irq_mask <= '0;
      irq_out <= 1'b0;
    end
    else
    begin
      if (wr_go && (avs_address_in == IRQ_STATUS_OFS) && avs_byteenable_in[0])
      begin
        irq_status <= (irq_status & ~avs_writedata_in[IRQ_W-1:0]) | events;
      end
      else
      begin
        irq_status <= irq_status | events;
      end
      if (wr_go && (avs_address_in == IRQ_MASK_OFS) && avs_byteenable_in[0])
      begin
        irq_mask <= avs_writedata_in[IRQ_W-1:0];
      end
      irq_out <= |(irq_status & irq_mask);
    end
  end

  // Identify word 128 image
  always_comb
  begin
    word128 = 16'h0000;
    word128[0] = 1'b1;
    word128[1] = lock_en;
    word128[2] = (mode == MODE_LOCKED);
    word128[3] = (mode == MODE_FROZEN);
    word128[EXHAUST_BIT] = exhausted;  // [RULE14]
    word128[8] = level_max;
  end

  // Read mux; unmapped offsets and the password buffer read as zero
  always_comb
  begin
    case (avs_address_in)
      CMD_OFS: next_rdata = {30'h0, result};
      STATUS_OFS: next_rdata = {21'h0, prepared, miss_cnt, lock_en, level_max, 2'h0, mode};
      IDENT_OFS: next_rdata = {word128, master_rev};  // [RULE10]
      IRQ_STATUS_OFS: next_rdata = {29'h0, irq_status};
      IRQ_MASK_OFS: next_rdata = {29'h0, irq_mask};
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // Output registers
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_b_in)
    begin
      avs_readdata_out <= 32'h0000_0000;
      media_enable_out <= 1'b1;
      mode_out <= MODE_UNLOCKED;
    end
    else
    begin
      if (avs_read_in && avs_waitrequest_out)
      begin
        avs_readdata_out <= next_rdata;
      end
      media_enable_out <= (mode != MODE_LOCKED);  // [RULE3]
      mode_out <= mode;
    end
  end

  // Checks
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_b_in);

  a_locked_media_abort: assert property (exec && cmd.media && mode == MODE_LOCKED  // [RULE2]
    |=> result.aborted && media_enable_out == 1'b0)
    else $error("media command ran while locked");
  a_unlock_opens: assert property (exec && cmd.opcode == OP_UNLOCK && !cmd.media &&  // [RULE3]
    !cmd.sel_master && mode == MODE_LOCKED && !exhausted && pw_buf == user_pw && !hard_rst
    |=> mode == MODE_UNLOCKED ##1 media_enable_out)
    else $error("good unlock did not unlock");
  a_hard_reset_mode: assert property (hard_rst |=> mode == ($past(lock_en) ?  // [RULE12]
    MODE_LOCKED : MODE_UNLOCKED))
    else $error("hard reset mode wrong");
  a_frozen_guard: assert property (exec && mode == MODE_FROZEN &&  // [RULE5]
    (cmd.opcode == OP_SET_PW || cmd.opcode == OP_DISABLE_PW) |=> result.aborted)
    else $error("frozen mode took a password change");
  a_frozen_stays: assert property (mode == MODE_FROZEN && !hard_rst  // [RULE6]
    |=> mode == MODE_FROZEN)
    else $error("left frozen mode by command");
  a_master_no_lock: assert property (exec && cmd.opcode == OP_SET_PW && cmd.sel_master  // [RULE9]
    && !lock_en |=> !lock_en)
    else $error("master password enabled lock");
  a_miss_counts: assert property (miss && miss_cnt < MISMATCH_LIMIT && !hard_rst  // [RULE13]
    |=> miss_cnt == $past(miss_cnt) + 3'h1)
    else $error("mismatch not counted");
  a_exhaust_abort: assert property (exhausted && exec &&  // [RULE14]
    (cmd.opcode == OP_UNLOCK || cmd.opcode == OP_ERASE_UNIT) |=> result.aborted)
    else $error("unlock ran after attempts exhausted");
  a_hard_clears: assert property (hard_rst |=> miss_cnt == 3'h0 && !exhausted)  // [RULE15]
    else $error("hard reset left mismatch state");
  a_count_sat: assert property (miss_cnt <= MISMATCH_LIMIT &&  // [RULE17]
    (exhausted == (miss_cnt == MISMATCH_LIMIT)))
    else $error("mismatch counter out of range");
  a_rev_valid: assert property (master_rev >= REV_MIN && master_rev <= REV_MAX)  // [RULE10]
    else $error("revision code out of range");

  c_unlock_done: cover property (mode == MODE_LOCKED ##1 mode == MODE_UNLOCKED);
  c_frozen: cover property (mode == MODE_FROZEN);
  c_exhausted: cover property ($rose(exhausted));
  c_erase: cover property (erase_out);

endmodule

// [sim/host_ctrl_model.sv]
// Host controller model that issues register accesses over Avalon-MM
`timescale 1ns/10ps
module host_ctrl_model (
  input wire logic clk_in,              // Bus clock
  input wire logic waitrequest_in,      // Slave stall
  input wire logic [31:0] readdata_in,  // Read data from the slave
  output logic [7:0] address_out,       // Byte address
  output logic read_out,                // Read request
  output logic write_out,               // Write request
  output logic [3:0] byteenable_out,    // Write byte lanes
  output logic [31:0] writedata_out     // Write data
);
  // Idle bus at time zero
  initial
  begin
    address_out = 8'h00;
    read_out = 1'b0;
    write_out = 1'b0;
    byteenable_out = 4'hF;
    writedata_out = 32'h0000_0000;
  end

  // Request held until waitrequest is seen low; released data is inverted so stale
  // values cannot pass for fresh ones
  task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    address_out <= a;
    writedata_out <= d;
    byteenable_out <= 4'hF;
    write_out <= 1'b1;
    do @(posedge clk_in); while (waitrequest_in !== 1'b0);
    write_out <= 1'b0;
    writedata_out <= ~d;
  endtask

  // Read data is taken at the same edge that sees waitrequest low
  task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_in);
    address_out <= a;
    read_out <= 1'b1;
    do @(posedge clk_in); while (waitrequest_in !== 1'b0);
    d = readdata_in;
    read_out <= 1'b0;
  endtask
endmodule

// [sim/drive_security_lock_fsm_bench.sv]
// Self-checking bench for the drive security lock state machine
`timescale 1ns/10ps
module drive_security_lock_fsm_bench;
  import sec_lock_pkg::*;
  localparam logic [1:0] RES_DONE = 2'h1;
  localparam logic [1:0] RES_ABORT = 2'h2;
  localparam logic [31:0] USER_PW = 32'h1357_9BDF;
  localparam logic [31:0] MASTER_PW = 32'hC0DE_0042;
  logic ref_clk_in;
  logic rst_b_in;
  logic hard_reset_b_in;
  logic [7:0] address;
  logic rd;
  logic wr;
  logic [3:0] byteenable;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic waitrequest;
  logic irq;
  logic media_enable;
  logic erase;
  lock_mode_t mode;
  logic [31:0] rdata;
  int num_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  int erase_pulses = 0;
  logic [7:0] locked_ops [3] = '{OP_SET_PW, OP_FREEZE, OP_DISABLE_PW};

  drive_security_lock_fsm drive_security_lock_fsm_inst (
    .ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .hard_reset_b_in(hard_reset_b_in),
    .avs_address_in(address), .avs_read_in(rd), .avs_write_in(wr),
    .avs_byteenable_in(byteenable), .avs_writedata_in(writedata),
    .avs_readdata_out(readdata), .avs_waitrequest_out(waitrequest), .irq_out(irq),
    .media_enable_out(media_enable), .erase_out(erase), .mode_out(mode)
  );

  host_ctrl_model host_ctrl_model_inst (
    .clk_in(ref_clk_in), .waitrequest_in(waitrequest), .readdata_in(readdata),
    .address_out(address), .read_out(rd), .write_out(wr),
    .byteenable_out(byteenable), .writedata_out(writedata)
  );

  // 125 MHz clock
  initial
  begin
    ref_clk_in = 1'b0;
    forever #4 ref_clk_in = ~ref_clk_in;
  end

  // Cycle ceiling well above the few hundred cycles the tests need; erase pulse count
  always @(posedge ref_clk_in)
  begin
    cycles++;
    if (erase === 1'b1)
      erase_pulses++;
    if (cycles == 20000)
    begin
      num_errors++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Opcode sits in the low byte of the command word
  function automatic cmd_word_t mk(logic [7:0] op, logic mst, logic lvl, logic med);
    mk = '{16'h0000, 5'h00, lvl, mst, med, op};
  endfunction

  // Password first, then command, then the outcome from the command register
  task automatic run_cmd(input cmd_word_t c, input logic [31:0] pw, input logic [1:0] exp);
    host_ctrl_model_inst.bus_write(PASSWORD_OFS, pw);
    host_ctrl_model_inst.bus_write(CMD_OFS, c);
    host_ctrl_model_inst.bus_read(CMD_OFS, rdata);
    check($sformatf("result of %h", c.opcode), {30'h0, rdata[1:0]}, {30'h0, exp});
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                        input string what);
    host_ctrl_model_inst.bus_read(a, rdata);
    check(what, rdata & m, e);
  endtask

  task automatic check_mode(input lock_mode_t m, input logic me);
    check("mode", {29'h0, mode}, {29'h0, m});
    check("media enable", {31'h0, media_enable}, {31'h0, me});
  endtask

  // Synchroniser lag is two to three cycles, so the pulse and settle time cover it
  task automatic hard_reset();
    @(posedge ref_clk_in);
    hard_reset_b_in <= 1'b0;
    repeat (4) @(posedge ref_clk_in);
    hard_reset_b_in <= 1'b1;
    repeat (5) @(posedge ref_clk_in);
  endtask

  initial
  begin
    rst_b_in = 1'b0;
    hard_reset_b_in = 1'b1;
    repeat (10) @(posedge ref_clk_in);
    rst_b_in <= 1'b1;
    check_mode(MODE_UNLOCKED, 1'b1);
    rd_chk(IDENT_OFS, 32'h0000_FFFF, 32'h0000_FFFE, "revision default");
    rd_chk(8'h18, 32'hFFFF_FFFF, 32'h0000_0000, "unmapped read");
    $display("test power-on done");

    run_cmd(mk(OP_SET_PW, 1'b1, 1'b0, 1'b0) | 32'h1234_0000, MASTER_PW, RES_DONE);
    rd_chk(IDENT_OFS, 32'h0000_FFFF, 32'h0000_1234, "revision");
    rd_chk(STATUS_OFS, 32'h0000_0040, 32'h0000_0000, "lock after master");
    run_cmd(mk(OP_SET_PW, 1'b1, 1'b0, 1'b0) | 32'hFFFF_0000, MASTER_PW, RES_DONE);
    rd_chk(IDENT_OFS, 32'h0000_FFFF, 32'h0000_1234, "revision kept");
    run_cmd(mk(OP_SET_PW, 1'b0, 1'b0, 1'b0), USER_PW, RES_DONE);
    rd_chk(STATUS_OFS, 32'h0000_0047, 32'h0000_0042, "lock on, still open");
    $display("test passwords done");

    hard_reset();
    check_mode(MODE_LOCKED, 1'b0);
    run_cmd(mk(8'h25, 1'b0, 1'b0, 1'b1), USER_PW, RES_ABORT);
    foreach (locked_ops[i])
      run_cmd(mk(locked_ops[i], 1'b0, 1'b0, 1'b0), USER_PW, RES_ABORT);
    run_cmd(mk(OP_UNLOCK, 1'b1, 1'b0, 1'b0), MASTER_PW, RES_DONE);
    check_mode(MODE_UNLOCKED, 1'b1);
    $display("test locked mode done");

    hard_reset();
    host_ctrl_model_inst.bus_write(IRQ_MASK_OFS, 32'h0000_0004);
    for (int i = 1; i <= 5; i++)
    begin
      run_cmd(mk(OP_UNLOCK, i[0], 1'b0, 1'b0), 32'hBAD0_0000, RES_ABORT);
      rd_chk(STATUS_OFS, 32'h0000_0380, i << 7, "mismatch count");
    end
    rd_chk(IDENT_OFS, 32'h0010_0000, 32'h0010_0000, "exhausted flag");
    check("irq raised", {31'h0, irq}, 32'h1);
    run_cmd(mk(OP_UNLOCK, 1'b0, 1'b0, 1'b0), USER_PW, RES_ABORT);
    run_cmd(mk(OP_ERASE_UNIT, 1'b1, 1'b0, 1'b0), MASTER_PW, RES_ABORT);
    rd_chk(STATUS_OFS, 32'h0000_0380, 32'h0000_0280, "count saturated");
    host_ctrl_model_inst.bus_write(IRQ_MASK_OFS, 32'h0000_0000);
    repeat (2) @(posedge ref_clk_in);
    check("irq masked", {31'h0, irq}, 32'h0);
    host_ctrl_model_inst.bus_write(IRQ_MASK_OFS, 32'h0000_0004);
    repeat (2) @(posedge ref_clk_in);
    check("irq unmasked", {31'h0, irq}, 32'h1);
    host_ctrl_model_inst.bus_write(IRQ_STATUS_OFS, 32'h0000_0004);
    repeat (2) @(posedge ref_clk_in);
    check("irq cleared", {31'h0, irq}, 32'h0);
    hard_reset();
    rd_chk(STATUS_OFS, 32'h0000_0387, 32'h0000_0001, "count cleared");
    rd_chk(IDENT_OFS, 32'h0010_0000, 32'h0000_0000, "flag cleared");
    $display("test attempt limit done");

    run_cmd(mk(OP_UNLOCK, 1'b0, 1'b0, 1'b0), USER_PW, RES_DONE);
    run_cmd(mk(OP_FREEZE, 1'b0, 1'b0, 1'b0), USER_PW, RES_DONE);
    check_mode(MODE_FROZEN, 1'b1);
    for (int op = 8'hF1; op <= 8'hF6; op++)
      if (op != 8'hF5)
        run_cmd(mk(op[7:0], 1'b0, 1'b0, 1'b0), USER_PW, RES_ABORT);
    run_cmd(mk(8'h25, 1'b0, 1'b0, 1'b1), USER_PW, RES_DONE);
    check_mode(MODE_FROZEN, 1'b1);
    $display("test frozen mode done");

    hard_reset();
    run_cmd(mk(OP_UNLOCK, 1'b0, 1'b0, 1'b0), USER_PW, RES_DONE);
    run_cmd(mk(OP_SET_PW, 1'b0, 1'b1, 1'b0), USER_PW, RES_DONE);
    hard_reset();
    run_cmd(mk(OP_UNLOCK, 1'b1, 1'b0, 1'b0), MASTER_PW, RES_ABORT);
    run_cmd(mk(OP_ERASE_PREP, 1'b1, 1'b0, 1'b0), MASTER_PW, RES_DONE);
    run_cmd(mk(OP_ERASE_UNIT, 1'b1, 1'b0, 1'b0), MASTER_PW, RES_DONE);
    check("erase pulses", erase_pulses, 32'h1);
    check_mode(MODE_UNLOCKED, 1'b1);
    $display("test maximum level done");
    summarize();
  end
endmodule
